// >>> pkg/bai_pkg.sv
package bai_pkg;
    localparam logic [3:0] ADDR_CONFIG = 4'h7;
    localparam logic [3:0] ADDR_UNLOCK = 4'h8;
    localparam logic [3:0] ADDR_TOP = 4'hA;
    localparam logic [3:0] ADDR_ZERO = 4'h0;
    localparam int UNLOCK_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A; // Arbitrary value
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_PRE = 4'hF;
    localparam int NUM_REGS = 11;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SLAVE = 5'b00010,
        ST_ADDR = 5'b00100,
        ST_WDATA = 5'b01000,
        ST_RDATA = 5'b10000
    } bai_state_type;
endpackage

// >>> design/bai_regfile.sv
`timescale 1ns/1ns
module bai_regfile (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [7:0] config_value
);
    logic [7:0] regs [bai_pkg::NUM_REGS];
    logic unlocked;

    assign unlocked = regs[bai_pkg::ADDR_UNLOCK][bai_pkg::UNLOCK_BIT];

    // -----------------------------------------------------------
    // Register array
    // -----------------------------------------------------------
    for (genvar i = 0; i < bai_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                regs[i] <= bai_pkg::REG_RESET;
            end else if (clk_en && wr_en && addr == 4'(i)) begin
                if (4'(i) != bai_pkg::ADDR_CONFIG || unlocked) begin
                    regs[i] <= wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= bai_pkg::REG_RESET;
            config_value <= bai_pkg::REG_RESET;
        end else if (clk_en) begin
            rdata <= (addr <= bai_pkg::ADDR_TOP) ? regs[addr]
                                                 : bai_pkg::REG_RESET;
            config_value <= regs[bai_pkg::ADDR_CONFIG];
        end
    end

    a_config_locked: assert property (@(posedge core_clk)
        disable iff (!nrst) clk_en && !unlocked && !$past(unlocked) |=>
        $stable(regs[bai_pkg::ADDR_CONFIG]))
        else $error("config changed while locked");
endmodule

// >>> design/bai_i2c_port.sv
`timescale 1ns/1ns
module bai_i2c_port #(
    parameter logic [6:0] SLAVE_ADDR = bai_pkg::SLAVE_ADDR_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] config_value,
    output logic busy
);
    typedef struct packed {
        bai_pkg::bai_state_type st;
        logic scl_d;
        logic sda_d;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [3:0] ptr;
        logic rd_mode;
        logic sda_oe;
        logic wr_en;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
        logic busy;
    } bai_port_type;

    bai_port_type cur, next_cur;
    logic [7:0] rdata;
    logic start_det, stop_det, scl_rise, scl_fall;

    default clocking cb_main @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // -----------------------------------------------------------
    // Bus condition detection
    // -----------------------------------------------------------
    assign start_det = cur.scl_d && scl_in && cur.sda_d && !sda_in;
    assign stop_det = cur.scl_d && scl_in && !cur.sda_d && sda_in;
    assign scl_rise = !cur.scl_d && scl_in;
    assign scl_fall = cur.scl_d && !scl_in;

    bai_regfile u_regs (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr_en(cur.wr_en),
        .addr(cur.wr_en ? cur.wr_addr : cur.ptr),
        .wdata(cur.wr_data),
        .rdata(rdata),
        .config_value(config_value)
    );

    function automatic logic [3:0] inc_ptr(input logic [3:0] p);
        inc_ptr = (p >= bai_pkg::ADDR_TOP) ? bai_pkg::ADDR_ZERO
                                           : p + 4'h1;
    endfunction

    // -----------------------------------------------------------
    // Protocol engine
    // -----------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.scl_d = scl_in;
        next_cur.sda_d = sda_in;
        next_cur.wr_en = 1'b0;
        next_cur.busy = (cur.st != bai_pkg::ST_IDLE);
        if (start_det) begin
            next_cur.st = bai_pkg::ST_SLAVE;
            next_cur.bitcnt = bai_pkg::BIT_PRE;
            next_cur.sda_oe = 1'b0;
        end else if (stop_det) begin
            next_cur.st = bai_pkg::ST_IDLE;
            next_cur.sda_oe = 1'b0;
        end else if (scl_rise && cur.st != bai_pkg::ST_IDLE) begin
            if (cur.st == bai_pkg::ST_RDATA) begin
                if (cur.bitcnt == bai_pkg::BIT_ACK && sda_in) begin
                    next_cur.st = bai_pkg::ST_IDLE;
                end
            end else if (cur.bitcnt <= bai_pkg::BIT_LAST) begin
                next_cur.shift = {cur.shift[6:0], sda_in};
            end
        end else if (scl_fall && cur.st != bai_pkg::ST_IDLE) begin
            next_cur.bitcnt = cur.bitcnt + 4'h1;
            next_cur.sda_oe = 1'b0;
            unique case (cur.st)
                bai_pkg::ST_SLAVE: begin
                    if (cur.bitcnt == bai_pkg::BIT_LAST) begin
                        if (cur.shift[7:1] == SLAVE_ADDR) begin
                            next_cur.sda_oe = 1'b1;
                            next_cur.rd_mode = cur.shift[0];
                        end else begin
                            next_cur.st = bai_pkg::ST_IDLE;
                        end
                    end else if (cur.bitcnt == bai_pkg::BIT_ACK) begin
                        next_cur.bitcnt = bai_pkg::BIT_ZERO;
                        if (cur.rd_mode) begin
                            next_cur.st = bai_pkg::ST_RDATA;
                            next_cur.shift = rdata;
                            next_cur.sda_oe = !rdata[7];
                        end else begin
                            next_cur.st = bai_pkg::ST_ADDR;
                        end
                    end
                end
                bai_pkg::ST_ADDR: begin
                    if (cur.bitcnt == bai_pkg::BIT_LAST) begin
                        next_cur.sda_oe = 1'b1;
                        next_cur.ptr = cur.shift[3:0];
                    end else if (cur.bitcnt == bai_pkg::BIT_ACK) begin
                        next_cur.bitcnt = bai_pkg::BIT_ZERO;
                        next_cur.st = bai_pkg::ST_WDATA;
                    end
                end
                bai_pkg::ST_WDATA: begin
                    if (cur.bitcnt == bai_pkg::BIT_LAST) begin
                        next_cur.sda_oe = 1'b1;
                        next_cur.wr_en = 1'b1;
                        next_cur.wr_addr = cur.ptr;
                        next_cur.wr_data = cur.shift;
                    end else if (cur.bitcnt == bai_pkg::BIT_ACK) begin
                        next_cur.bitcnt = bai_pkg::BIT_ZERO;
                        next_cur.ptr = inc_ptr(cur.ptr);
                    end
                end
                bai_pkg::ST_RDATA: begin
                    if (cur.bitcnt == bai_pkg::BIT_LAST) begin
                        next_cur.ptr = inc_ptr(cur.ptr);
                    end else if (cur.bitcnt == bai_pkg::BIT_ACK) begin
                        next_cur.bitcnt = bai_pkg::BIT_ZERO;
                        next_cur.shift = rdata;
                        next_cur.sda_oe = !rdata[7];
                    end else begin
                        next_cur.shift = {cur.shift[6:0], 1'b0};
                        next_cur.sda_oe = !cur.shift[6];
                    end
                end
                default: next_cur.st = bai_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '{st: bai_pkg::ST_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                     bitcnt: bai_pkg::BIT_ZERO, shift: bai_pkg::REG_RESET,
                     ptr: bai_pkg::ADDR_ZERO, rd_mode: 1'b0, sda_oe: 1'b0,
                     wr_en: 1'b0, wr_addr: bai_pkg::ADDR_ZERO,
                     wr_data: bai_pkg::REG_RESET, busy: 1'b0};
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = cur.sda_oe;
    assign busy = cur.busy;

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    sequence s_stop;
        clk_en && stop_det;
    endsequence

    sequence s_start;
        clk_en && start_det;
    endsequence

    sequence s_eighth_fall;
        clk_en && scl_fall && cur.bitcnt == bai_pkg::BIT_LAST;
    endsequence

    sequence s_ninth_fall;
        clk_en && scl_fall && cur.bitcnt == bai_pkg::BIT_ACK;
    endsequence

    a_stop_idle: assert property (
        s_stop |=> cur.st == bai_pkg::ST_IDLE && !sda_oe)
        else $error("stop did not release port");

    a_idle_quiet: assert property (
        cur.st == bai_pkg::ST_IDLE && !(clk_en && start_det) |=> !sda_oe)
        else $error("port drove bus while idle");

    a_sda_change: assert property (
        $changed(sda_oe) |-> !cur.scl_d || $past(start_det || stop_det))
        else $error("data changed while clock high");

    a_wrap_addr: assert property (
        s_ninth_fall ##0 (cur.st == bai_pkg::ST_WDATA &&
        cur.ptr == bai_pkg::ADDR_TOP) |=> cur.ptr == bai_pkg::ADDR_ZERO)
        else $error("address did not wrap");

    a_commit_fall: assert property (
        cur.wr_en |-> $past(scl_fall) &&
        $past(cur.bitcnt) == bai_pkg::BIT_LAST)
        else $error("write not on eighth falling edge");

    a_ack_write: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_ADDR ||
        cur.st == bai_pkg::ST_WDATA) |=> sda_oe)
        else $error("write byte not acked");

    a_nomatch: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_SLAVE &&
        cur.shift[7:1] != SLAVE_ADDR) |=> !sda_oe &&
        cur.st == bai_pkg::ST_IDLE)
        else $error("mismatched slave byte acked");

    a_read_nack: assert property (
        clk_en && scl_rise && cur.st == bai_pkg::ST_RDATA &&
        cur.bitcnt == bai_pkg::BIT_ACK && sda_in && !start_det
        |=> cur.st == bai_pkg::ST_IDLE ##1 !sda_oe)
        else $error("read continued after nack");

    a_read_inc: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_RDATA)
        |=> cur.ptr == inc_ptr($past(cur.ptr)))
        else $error("read pointer not advanced");

    a_start_slave: assert property (
        s_start |=> cur.st == bai_pkg::ST_SLAVE &&
        cur.bitcnt == bai_pkg::BIT_PRE && !sda_oe)
        else $error("start not taken");

    a_pre_fall: assert property (
        clk_en && scl_fall && cur.st != bai_pkg::ST_IDLE &&
        cur.bitcnt == bai_pkg::BIT_PRE |=> cur.bitcnt == bai_pkg::BIT_ZERO)
        else $error("first fall after start counted");

    a_match_ack: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_SLAVE &&
        cur.shift[7:1] == SLAVE_ADDR) |=> sda_oe)
        else $error("matching slave byte not acked");

    a_ack_release: assert property (
        s_ninth_fall ##0 (cur.st != bai_pkg::ST_RDATA &&
        !(cur.st == bai_pkg::ST_SLAVE && cur.rd_mode)) |=> !sda_oe)
        else $error("ack not released");

    a_read_release: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_RDATA) |=> !sda_oe)
        else $error("read byte not released");

    a_write_inc: assert property (
        s_ninth_fall ##0 (cur.st == bai_pkg::ST_WDATA)
        |=> cur.ptr == inc_ptr($past(cur.ptr)))
        else $error("write pointer not advanced");

    a_write_data: assert property (
        cur.wr_en |-> cur.wr_data == $past(cur.shift))
        else $error("committed byte differs");

    a_rd_enter: assert property (
        s_ninth_fall ##0 (cur.st == bai_pkg::ST_SLAVE && cur.rd_mode)
        |=> cur.st == bai_pkg::ST_RDATA)
        else $error("read slave byte not followed by data");

    a_read_drive: assert property (
        s_ninth_fall ##0 (cur.st == bai_pkg::ST_RDATA)
        |=> sda_oe == !$past(rdata[7]))
        else $error("next read byte not driven");

    a_read_wrap: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_RDATA &&
        cur.ptr == bai_pkg::ADDR_TOP) |=> cur.ptr == bai_pkg::ADDR_ZERO)
        else $error("read pointer did not wrap");

    a_addr_load: assert property (
        s_eighth_fall ##0 (cur.st == bai_pkg::ST_ADDR)
        |=> cur.ptr == $past(cur.shift[3:0]))
        else $error("address byte not loaded");
endmodule

// >>> bench/bai_master.sv
`timescale 1ns/1ns
// ------------------------------
// Two-wire bus master model
// ------------------------------
module bai_master (
    input wire logic core_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_drv,
    output logic sda_line
);
    localparam int HALF = 4;
    // Pull-up line: released reads high
    assign sda_line = sda_drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic clk_bit(input logic b, output logic s);
        sda_drv <= b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        s = sda_line;
        scl <= 1'b0;
        tick(HALF);
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
        tick(HALF);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b1;
        tick(HALF);
    endtask
    task automatic tx_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic rx_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(~ack_it, s);
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } bai_row_type;
    localparam logic [6:0] SA = 7'h55; // Arbitrary slave address
    logic core_clk;
    logic nrst;
    logic clk_en;
    logic scl;
    logic sda_drv;
    logic sda_line;
    logic sda_oe;
    logic [7:0] config_value;
    logic busy;
    logic sda_out;
    logic [7:0] got;
    logic ack;
    int n_fail;
    int samples_checked;
    bai_row_type rows [8] = '{'{8'h07, 8'h3C, 8'h00},
        '{8'h08, 8'h80, 8'h80}, '{8'h07, 8'h3C, 8'h3C},
        '{8'h08, 8'h00, 8'h00}, '{8'h07, 8'h11, 8'h3C},
        '{8'h00, 8'h5A, 8'h5A}, '{8'h01, 8'hC3, 8'hC3},
        '{8'h02, 8'hA5, 8'hA5}};
    // ------------------------------
    // Design and bus master
    // ------------------------------
    bai_i2c_port #(.SLAVE_ADDR(SA)) i_bai_i2c_port (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .config_value(config_value),
        .busy(busy)
    );
    bai_master i_bai_master (
        .core_clk(core_clk),
        .sda_oe(sda_oe),
        .scl(scl),
        .sda_drv(sda_drv),
        .sda_line(sda_line)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic write_regs(input logic [7:0] a, input logic [7:0] d [$]);
        i_bai_master.start();
        i_bai_master.tx_byte({SA, 1'b0}, ack);
        `CHK(ack, 1'b1)
        i_bai_master.tx_byte(a, ack);
        `CHK(ack, 1'b1)
        foreach (d[i]) begin
            i_bai_master.tx_byte(d[i], ack);
            `CHK(ack, 1'b1)
        end
        i_bai_master.stop();
    endtask
    task automatic read_regs(input logic [7:0] a, input logic set_ptr,
                             input logic [7:0] exp [$]);
        if (set_ptr) begin
            i_bai_master.start();
            i_bai_master.tx_byte({SA, 1'b0}, ack);
            `CHK(ack, 1'b1)
            i_bai_master.tx_byte(a, ack);
            `CHK(ack, 1'b1)
        end
        i_bai_master.start();
        i_bai_master.tx_byte({SA, 1'b1}, ack);
        `CHK(ack, 1'b1)
        foreach (exp[i]) begin
            i_bai_master.rx_byte(i < exp.size() - 1, got);
            `CHK(got, exp[i])
        end
        i_bai_master.stop();
        `CHK(busy, 1'b0)
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        summarize();
    end
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        n_fail = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk);
        `CHK(config_value, 8'h00)
        `CHK(busy, 1'b0)
        `CHK(sda_oe, 1'b0)
        nrst <= 1'b1;
        @(posedge core_clk);
        i_bai_master.tx_byte({SA, 1'b0}, ack);
        `CHK(ack, 1'b0)
        `CHK(busy, 1'b0)
        $display("test reset and no-start done");
        foreach (rows[i]) begin
            write_regs(rows[i].addr, {rows[i].data});
            read_regs(rows[i].addr, 1'b1, {rows[i].exp});
            if (rows[i].addr == 8'h07) begin
                `CHK(config_value, rows[i].exp)
            end
        end
        $display("test register rows done");
        write_regs(8'h05, {8'h11, 8'h22});
        read_regs(8'h05, 1'b1, {8'h11, 8'h22});
        read_regs(8'h0A, 1'b1, {8'h00, 8'h5A});
        read_regs(8'h00, 1'b0, {8'hC3});
        $display("test burst wrap and current read done");
        i_bai_master.start();
        `CHK(busy, 1'b1)
        i_bai_master.tx_byte({SA ^ 7'h01, 1'b0}, ack);
        `CHK(ack, 1'b0)
        `CHK(busy, 1'b0)
        i_bai_master.tx_byte(8'h07, ack);
        `CHK(ack, 1'b0)
        i_bai_master.stop();
        `CHK(busy, 1'b0)
        `CHK(sda_out, 1'b0)
        $display("test foreign slave done");
        summarize();
    end
endmodule
